// ==== pkg/reset_cause_pkg.sv ====
/*
  Constants and carriers for the reset cause logic: register map, flag bit
  positions, event bundle and sequencer states.
  Assumes a 32-bit APB bus clocked by pclk at 125 MHz.
*/
package reset_cause_pkg;
  localparam logic [11:0] cause_reg_addr = 12'h000;
  localparam logic [11:0] watch_reg_addr = 12'h004;
  localparam logic [11:0] status_reg_addr = 12'h008;
  localparam int trap_bit = 15;
  localparam int illegal_bit = 14;
  localparam int mismatch_bit = 9;
  localparam int external_pin_reset_flag_bit = 7;
  localparam int swr_bit = 6;
  localparam int watchdog_timeout_flag_bit = 4;
  localparam int sleep_bit = 3;
  localparam int idle_bit = 2;
  localparam int bor_bit = 1;
  localparam int por_bit = 0;
  localparam logic [15:0] cause_reset_value = 16'h0003;
  localparam logic [15:0] cause_impl_mask = 16'hc2df;
  localparam logic [7:0] illegal_opcode_upper = 8'h3f;
  localparam int num_working_regs = 16;
  localparam logic [3:0] top_working_reg = 4'hf;
  localparam int hard_trap_min = 13;
  localparam int hard_trap_max = 15;
  localparam logic [3:0] reset_hold_cycles = 4'h1;

  typedef struct packed {
    logic soft_reset;
    logic watchdog_timeout;
    logic power_save_sleep;
    logic power_save_idle;
    logic watchdog_clear;
    logic in_low_power;
    logic trap_valid;
    logic [3:0] trap_level;
    logic [3:0] active_trap_level;
    logic trap_active;
    logic fetch_valid;
    logic [7:0] fetch_upper;
    logic ptr_use;
    logic [3:0] ptr_reg;
    logic reg_write;
    logic [3:0] reg_write_idx;
    logic flow_change;
    logic vector_change;
    logic target_restricted;
  } core_events_s;

  typedef enum logic [1:0] {
    run_st = 2'b00,
    hold_st = 2'b01,
    release_st = 2'b11
  } seq_state_e;
endpackage : reset_cause_pkg

// ==== hdl/reset_cause_logic.sv ====
/*
  Reset cause logic: gathers reset sources, drives system_reset_n and keeps
  the reset cause register reachable over APB.
  Assumes power-on and brown-out come from analog supervisors as async pins,
  and the core reports its events synchronously on pclk.
*/
// Chosen here: the placing of the registers and the APB register port.
// Contract
// - Soft reset instruction pulses reset one cycle, clock source untouched.
// - Soft reset sets cause bit 6.
// - Watchdog time-out while running asserts reset asynchronously.
// - Watchdog time-out in sleep or idle only wakes, no reset.
// - Watchdog reset sets cause bit 4.
// - Lower hard trap during higher trap processing resets device.
// - Trap conflict sets cause bit 15.
// - Pin-select registers continuously compared with shadow; mismatch resets.
// - Mismatch reset sets cause bit 9.
// - Illegal opcode, uninit register, security each reset, set bit 14.
// - Executing fetched opcode with upper byte 0x3f resets device.
// - Resets clear all working regs but top; uninit pointer use resets.
// - Flow change into restricted protected location causes security reset.
// - Branches are program flow changes; vector reloads are vector changes.
// - Watchdog flag cleared by power-save, watchdog clear, power-on, brown-out.
// - Trap, illegal, mismatch, soft, sleep, idle cleared by hardware only on cold reset.
// - Software may set or clear every cause flag directly.
// - Master clear pin driven low resets the device.
// - Master clear reset sets the external-pin flag.
// - Power-on reset sets the power-on flag.
// - Software setting a flag never triggers reset.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_logic
  import reset_cause_pkg::*;
#(
  parameter int pps_regs = 4,
  parameter int pps_width = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic por_n,
  input wire logic bor_n,
  input wire logic master_clear_pin,
  input wire core_events_s core_events,
  input wire logic [pps_regs*pps_width-1:0] pps_ctrl,
  input wire logic [pps_regs*pps_width-1:0] pps_shadow,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic system_reset_n,
  output logic watchdog_wake,
  output logic fetch_reset_vector,
  output logic [num_working_regs-1:0] reg_initialized
);
  logic [2:0] sync0, sync1, next_sync0, next_sync1;
  logic por_s, bor_s, master_clear_pin_s;
  logic [15:0] cause, next_cause;
  logic [num_working_regs-1:0] next_reg_init;
  seq_state_e state, next_state;
  logic [31:0] next_prdata;
  logic [pps_regs-1:0] pps_diff;
  logic wdt_reset, sync_reset, illegal_hit, trap_conflict, mismatch;
  logic security_hit, uninit_hit, opcode_hit, cold, apb_write, apb_read;
  logic mapped, incoming_hard, lower_priority, in_hold;
  logic [31:0] status_word;

  // Pins pass two flops before use
  always_comb begin
    next_sync0 = {master_clear_pin, bor_n, por_n};
    next_sync1 = sync0;
  end

  // Reset to the idle high level: a cleared stage would fake a pin event
  // and a second power-on right after presetn is released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync0 <= 3'h7;
      sync1 <= 3'h7;
    end else if (clk_en) begin
      sync0 <= next_sync0;
      sync1 <= next_sync1;
    end
  end
  assign por_s = ~sync1[0];
  assign bor_s = ~sync1[1];
  assign master_clear_pin_s = ~sync1[2];
  assign cold = por_s | bor_s;

  genvar gi;
  generate
    for (gi = 0; gi < pps_regs; gi++) begin : g_pps
      assign pps_diff[gi] = pps_ctrl[gi*pps_width +: pps_width]
                          != pps_shadow[gi*pps_width +: pps_width];
    end
  endgenerate
  assign mismatch = |pps_diff;

  // Watchdog time-out resets only while running; in low power it only wakes
  assign wdt_reset = core_events.watchdog_timeout
                   & ~core_events.in_low_power;
  assign watchdog_wake = core_events.watchdog_timeout
                       & core_events.in_low_power;
  // Only levels inside the hard band can conflict; soft traps just nest
  assign incoming_hard = (core_events.trap_level >= 4'(hard_trap_min))
    & (core_events.trap_level <= 4'(hard_trap_max));
  assign lower_priority = core_events.trap_level
    < core_events.active_trap_level;
  assign trap_conflict = core_events.trap_valid & core_events.trap_active
    & incoming_hard & lower_priority;
  assign opcode_hit = core_events.fetch_valid
    & (core_events.fetch_upper == illegal_opcode_upper);
  assign uninit_hit = core_events.ptr_use
    & ~reg_initialized[core_events.ptr_reg];
  assign security_hit = (core_events.flow_change | core_events.vector_change)
    & core_events.target_restricted;
  assign illegal_hit = opcode_hit | uninit_hit | security_hit;
  // Sources that pass through the sequencer and get a release cycle
  assign sync_reset = core_events.soft_reset
                    | trap_conflict
                    | mismatch
                    | illegal_hit
                    | master_clear_pin_s
                    | cold;

  assign in_hold = (state == hold_st);

  // Watchdog asserts reset straight through, no clock needed
  assign system_reset_n = ~(wdt_reset
                          | in_hold
                          | master_clear_pin_s
                          | cold);
  assign fetch_reset_vector = (state == release_st);

  assign apb_write = psel & penable & pwrite;
  assign apb_read = psel & ~penable & ~pwrite;
  // No wait states: every register answers in the access cycle
  assign pready = 1'b1;

  // Only three words decode; any other address answers with an error
  always_comb begin
    mapped = 1'b0;
    if (paddr == cause_reg_addr) begin
      mapped = 1'b1;
    end else if (paddr == watch_reg_addr) begin
      mapped = 1'b1;
    end else if (paddr == status_reg_addr) begin
      mapped = 1'b1;
    end
  end

  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    next_state = state;
    // Hold stays while any source persists, then one release cycle
    case (state)
      run_st: begin
        if (sync_reset) begin
          next_state = hold_st;
        end
      end
      hold_st: begin
        if (!sync_reset) begin
          next_state = release_st;
        end
      end
      release_st: begin
        // A new source during release goes straight back to hold
        next_state = sync_reset ? hold_st : run_st;
      end
      default: begin
        next_state = run_st;
      end
    endcase
  end

  always_comb begin
    next_cause = cause;
    // Software write first so hardware events win the same cycle
    if (apb_write && paddr == cause_reg_addr && pstrb[0]) begin
      next_cause[7:0] = pwdata[7:0];
    end
    if (apb_write && paddr == cause_reg_addr && pstrb[1]) begin
      next_cause[15:8] = pwdata[15:8];
    end
    next_cause = next_cause & cause_impl_mask;
    if (core_events.power_save_sleep || core_events.power_save_idle
        || core_events.watchdog_clear) begin
      next_cause[watchdog_timeout_flag_bit] = 1'b0;
    end
    if (core_events.power_save_sleep) begin
      next_cause[sleep_bit] = 1'b1;
    end
    if (core_events.power_save_idle) begin
      next_cause[idle_bit] = 1'b1;
    end
    if (core_events.soft_reset) begin
      next_cause[swr_bit] = 1'b1;
    end
    if (wdt_reset) begin
      next_cause[watchdog_timeout_flag_bit] = 1'b1;
    end
    if (trap_conflict) begin
      next_cause[trap_bit] = 1'b1;
    end
    if (mismatch) begin
      next_cause[mismatch_bit] = 1'b1;
    end
    if (illegal_hit) begin
      next_cause[illegal_bit] = 1'b1;
    end
    if (master_clear_pin_s) begin
      next_cause[external_pin_reset_flag_bit] = 1'b1;
    end
    // Cold resets clear every flag but set bor, and por on power-on; brown-out alone keeps the pin and power-on flags
    if (cold) begin
      next_cause = 16'h0;
      next_cause[external_pin_reset_flag_bit] = cause[external_pin_reset_flag_bit] & ~por_s;
      next_cause[bor_bit] = 1'b1;
      next_cause[por_bit] = por_s;
      if (!por_s) begin
        next_cause[por_bit] = cause[por_bit];
      end
    end
  end

  // Working-register init map, its own group
  always_comb begin
    next_reg_init = reg_initialized;
    if (core_events.reg_write) begin
      next_reg_init[core_events.reg_write_idx] = 1'b1;
    end
    // Any reset wipes the working set except the stack pointer
    if (!system_reset_n || in_hold) begin
      next_reg_init = '0;
      next_reg_init[top_working_reg] = 1'b1;
    end
  end

  // Status fields: sequencer state, then live illegal and mismatch hits
  always_comb begin
    status_word = 32'h0;
    status_word[1:0] = state;
    status_word[2] = illegal_hit;
    status_word[3] = mismatch;
  end

  // Reads are captured at setup so prdata stands through the access phase
  always_comb begin
    next_prdata = prdata;
    if (apb_read) begin
      if (paddr == cause_reg_addr) begin
        next_prdata = {16'h0, cause};
      end else if (paddr == watch_reg_addr) begin
        next_prdata = {16'h0, reg_initialized};
      end else if (paddr == status_reg_addr) begin
        next_prdata = status_word;
      end else begin
        next_prdata = 32'h0;
      end
    end
  end

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= run_st;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // Cause flags keep their value through warm resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause <= cause_reset_value;
    end else if (clk_en) begin
      cause <= next_cause;
    end
  end

  // Working-register map; presetn counts as a reset like any other
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_initialized <= 16'h8000;
    end else if (clk_en) begin
      reg_initialized <= next_reg_init;
    end
  end

  // Read data, captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (clk_en) begin
      prdata <= next_prdata;
    end
  end
endmodule : reset_cause_logic
`default_nettype wire

// ==== dv/reset_cause_properties.sv ====
/* Checker for the reset cause logic; bound to its top module.
   Assumes clk_en is held high by the bench. */
`timescale 1ns/1ps
`default_nettype none
module reset_cause_properties
  import reset_cause_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire core_events_s core_events,
  input wire logic master_clear_pin,
  input wire logic system_reset_n,
  input wire logic watchdog_wake,
  input wire logic fetch_reset_vector,
  input wire logic [num_working_regs-1:0] reg_initialized
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SOFT: assert property (core_events.soft_reset |=> !system_reset_n ##1
    (system_reset_n && fetch_reset_vector)) else $error("soft reset seq");
  AST_WDT: assert property (core_events.watchdog_timeout &&
    !core_events.in_low_power |-> !system_reset_n) else $error("wdt");
  AST_WAKE: assert property (core_events.watchdog_timeout &&
    core_events.in_low_power |-> watchdog_wake) else $error("wake");
  AST_TRAP: assert property (core_events.trap_valid && core_events.trap_active
    && core_events.trap_level >= 4'hd && core_events.trap_level <
    core_events.active_trap_level |-> ##[0:2] !system_reset_n)
    else $error("trap conflict");
  AST_OPC: assert property (core_events.fetch_valid && core_events.fetch_upper
    == illegal_opcode_upper |-> ##[0:2] !system_reset_n) else $error("opc");
  AST_SEC: assert property ((core_events.flow_change ||
    core_events.vector_change) && core_events.target_restricted |->
    ##[0:2] !system_reset_n) else $error("security");
  AST_PTR: assert property (core_events.ptr_use &&
    !reg_initialized[core_events.ptr_reg] |-> ##[0:2] !system_reset_n)
    else $error("uninit pointer");
  AST_TOP: assert property (reg_initialized[15]) else $error("top reg");
  // Two sync flops, so the third low sample must show reset
  AST_MASTER_CLEAR_PIN: assert property (!master_clear_pin [*3] |-> !system_reset_n)
    else $error("master clear");
endmodule : reset_cause_properties
bind reset_cause_logic reset_cause_properties u_reset_cause_properties (
  .pclk, .presetn, .core_events, .master_clear_pin, .system_reset_n,
  .watchdog_wake, .fetch_reset_vector, .reg_initialized);
`default_nettype wire

// ==== dv/supervisor_model.sv ====
/* External supervisor: master clear pin and brown-out pin.
   Assumes one-cycle requests from the bench on pclk. */
`timescale 1ns/1ps
`default_nettype none
module supervisor_model (
  input wire logic pclk,
  input wire logic master_clear_pin_req,
  input wire logic bor_req,
  output logic master_clear_pin,
  output logic bor_n,
  output logic por_n
);
  logic [2:0] mc_cnt = 3'h0;
  logic [2:0] bo_cnt = 3'h0;
  always @(posedge pclk) begin
    mc_cnt <= master_clear_pin_req ? 3'h5 : mc_cnt - 3'(mc_cnt != 3'h0);
    bo_cnt <= bor_req ? 3'h5 : bo_cnt - 3'(bo_cnt != 3'h0);
  end
  // Pulled up when idle; low long enough to pass the sync stages
  assign master_clear_pin = (mc_cnt == 3'h0);
  assign bor_n = (bo_cnt == 3'h0);
  assign por_n = 1'b1;
endmodule : supervisor_model
`default_nettype wire

// ==== dv/tb_top.sv ====
/* Testbench: APB master, core event driver and supervisor model.
   Assumes clk_en high and all byte lanes enabled. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import reset_cause_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, master_clear_pin_req, bor_req, last_err;
  logic master_clear_pin, bor_n, por_n, pready, pslverr, system_reset_n;
  logic watchdog_wake, fetch_reset_vector;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, pwd;
  logic [63:0] pps_ctrl, pps_shadow;
  logic [15:0] reg_initialized, exp;
  core_events_s ev, base;
  int n_mismatch, cmp_count;
  int pos[9] = '{swr_bit, trap_bit, illegal_bit, illegal_bit, illegal_bit,
    illegal_bit, watchdog_timeout_flag_bit, external_pin_reset_flag_bit, mismatch_bit};
  reset_cause_logic u_reset_cause_logic (.pclk, .presetn, .clk_en(1'b1),
    .por_n, .bor_n, .master_clear_pin, .core_events(ev), .pps_ctrl,
    .pps_shadow, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
    .prdata, .pready, .pslverr, .system_reset_n, .watchdog_wake,
    .fetch_reset_vector, .reg_initialized);
  supervisor_model u_supervisor_model (.pclk, .master_clear_pin_req, .bor_req,
    .master_clear_pin, .bor_n, .por_n);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [15:0] flag(input int k);
    return 16'h1 << pos[k];
  endfunction : flag
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic hang;
    chk(32'h0, 32'h1);
    give_verdict;
  endtask : hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) hang;
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wt(input logic lvl);
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge pclk);
      if (system_reset_n === lvl) break;
    end
    if (n == 40) hang;
  endtask : wt
  task automatic fire(input int k);
    @(posedge pclk);
    case (k)
      0: ev.soft_reset <= 1'b1;
      1: ev.trap_valid <= 1'b1;
      2: ev.fetch_valid <= 1'b1;
      3: ev.ptr_use <= 1'b1;
      4: ev.flow_change <= 1'b1;
      5: ev.vector_change <= 1'b1;
      6: ev.watchdog_timeout <= 1'b1;
      7: master_clear_pin_req <= 1'b1;
      8: pps_shadow[0] <= ~pps_ctrl[0];
      9: ev.watchdog_clear <= 1'b1;
      10: ev.power_save_sleep <= 1'b1;
      default: bor_req <= 1'b1;
    endcase
    @(posedge pclk);
    ev <= base;
    master_clear_pin_req <= 1'b0;
    bor_req <= 1'b0;
    pps_shadow <= pps_ctrl;
  endtask : fire
  initial begin
    {n_mismatch, cmp_count, psel, penable, pwrite, paddr, pwdata} = '0;
    {master_clear_pin_req, bor_req, presetn} = '0;
    void'($urandom(11));
    base = '0;
    base.trap_active = 1'b1;
    base.active_trap_level = 4'hf;
    base.trap_level = 4'hd;
    base.fetch_upper = illegal_opcode_upper;
    base.target_restricted = 1'b1;
    // Random pointer: every register but the top is uninitialized
    base.ptr_reg = 4'($urandom_range(14));
    ev = base;
    pps_ctrl = {$urandom, $urandom};
    pps_shadow = pps_ctrl;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cause_reg_addr, 32'h0);
    chk(rd, 32'(cause_reset_value)); // After power-on
    exp = cause_reset_value;
    for (int k = 0; k < 9; k++) begin
      apb(1'b1, cause_reg_addr, 32'(exp & ~flag(k))); // Clear it
      // Watchdog reset is a one-cycle pulse: watch while it fires
      fork
        fire(k);
        wt(1'b0);
      join
      wt(1'b1);
      exp |= flag(k);
      apb(1'b0, cause_reg_addr, 32'h0);
      chk(rd, 32'(exp)); // New flag
    end
    chk(32'(reg_initialized), 32'h8000); // Cleared by reset
    for (int k = 9; k < 11; k++) begin
      exp[watchdog_timeout_flag_bit] = 1'b1;
      apb(1'b1, cause_reg_addr, 32'(exp));
      fire(k);
      exp[watchdog_timeout_flag_bit] = 1'b0;
      exp[sleep_bit] = (k == 10);
      apb(1'b0, cause_reg_addr, 32'h0);
      chk(rd, 32'(exp)); // Watchdog flag cleared
    end
    @(posedge pclk);
    ev.in_low_power <= 1'b1;
    ev.watchdog_timeout <= 1'b1;
    @(negedge pclk);
    chk({watchdog_wake, system_reset_n}, 32'h3); // Wake, no reset
    fire(11);
    wt(1'b0);
    wt(1'b1);
    exp = (exp & 16'h0081) | 16'h0002;
    apb(1'b0, cause_reg_addr, 32'h0);
    chk(rd, 32'(exp)); // Brown-out clears
    repeat (4) begin
      pwd = $urandom;
      apb(1'b1, cause_reg_addr, pwd);
      apb(1'b0, cause_reg_addr, 32'h0);
      chk(rd, pwd & 32'(cause_impl_mask)); // Direct write
      chk(32'(system_reset_n), 32'h1); // No reset from it
    end
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0); // Unmapped word reads zero
    chk(32'(last_err), 32'h1); // Unmapped word flags an error
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
